// [hdl/led_mux_defines.vh]
// Register offsets, field positions and reset values of the indicator pin mux
`ifndef LED_MUX_DEFINES_VH
`define LED_MUX_DEFINES_VH

// Printed offsets 451h and 452h are not multiples of four: these are indices, byte address is index*4
`define IDX_COMPL_POL       12'h451
`define IDX_SRC_SEL         12'h452
`define IDX_OPTIONS         12'h454

`define COMPL_SEL_HI        11
`define COMPL_SEL_LO        9
`define POL1_BIT            3
`define POL0_BIT            0
`define SRC1_HI             10
`define SRC1_LO             8
`define SRC0_HI             2
`define SRC0_LO             0
`define OPT1_HI             7
`define OPT1_LO             4
`define OPT0_HI             3
`define OPT0_LO             0

`define RST_COMPL_POL       16'h0000
`define RST_SRC_SEL         16'h0000
`define RST_OPTIONS         16'h0010
`define RST_COMPL_SEL       3'h0
`define RST_SRC             3'h0
`define RST_OPT1            4'h1
`define RST_OPT0            4'h0

`define SRC_OWN             3'h0
`define SRC_MATCH           3'h2
`define SRC_UVOLT           3'h3
`define SRC_IRQ             3'h4
`define SRC_COMPL           3'h5
`define SRC_ZERO            3'h6
`define SRC_ONE             3'h7

`define OPT_LINK            4'h0
`define OPT_LINK_BLINK      4'h1

// Blink half period: 100 ms at 50 MHz
`define BLINK_MS            100
`define CLK_KHZ             50000
`define BLINK_CYC           (`BLINK_MS * `CLK_KHZ)

`endif

// [hdl/led_pin_source.v]
// One indicator pin: indicator function, source select and polarity
`timescale 1ns/1ps
`default_nettype none
module led_pin_source (
    input  wire       i_clk,
    input  wire       i_rst_b,
    input  wire [2:0] i_sel,
    input  wire [3:0] i_opt,
    input  wire       i_pol,
    input  wire       i_link,
    input  wire       i_act,
    input  wire       i_blink,
    input  wire       i_match,
    input  wire       i_uvolt,
    input  wire       i_irq,
    input  wire       i_compl,
    output reg        o_pin
);
`include "led_mux_defines.vh"
    reg indic;
    reg pin_d;

    always @* begin
        if (i_opt == `OPT_LINK_BLINK) begin
            indic = i_link & ~(i_act & i_blink);
        end else begin
            indic = i_link;
        end
    end

    always @* begin
        case (i_sel)
            `SRC_OWN:   pin_d = indic ^ i_pol;
            `SRC_MATCH: pin_d = i_match;
            `SRC_UVOLT: pin_d = i_uvolt;
            `SRC_IRQ:   pin_d = i_irq;
            `SRC_COMPL: pin_d = i_compl;
            `SRC_ZERO:  pin_d = 1'b0;
            `SRC_ONE:   pin_d = 1'b1;
            default:    pin_d = 1'b0;
        endcase
    end

    always @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_pin <= 1'b0;
        end else begin
            o_pin <= pin_d;
        end
    end
endmodule
`default_nettype wire

// [hdl/led_pin_output_mux.v]
// Indicator pin output mux with APB register access
`timescale 1ns/1ps
`default_nettype none
`include "led_mux_defines.vh"
// How it works
// - Compliance select picks the compliance signal for both pins
// - Pin 1 select chooses match, voltage, interrupt, compliance
// - Pin 1 code zero gives its indicator
// - Pin 0 select uses same codes
// - Pin 0 code zero gives its indicator
// - Codes six and seven force zero, one
// - All selects reset to zero
// - Option field: link, or link with blink
module led_pin_output_mux (
    input  wire        I_CLK,
    input  wire        I_RST_B,
    input  wire        I_PSEL,
    input  wire        I_PENABLE,
    input  wire        I_PWRITE,
    input  wire [13:0] I_PADDR,
    input  wire [31:0] I_PWDATA,
    output reg         O_PREADY,
    output reg  [31:0] O_PRDATA,
    output reg         O_PSLVERR,
    input  wire        I_LINK_UP,
    input  wire        I_ACTIVITY,
    input  wire        I_DATA_MATCH,
    input  wire        I_UNDER_VOLT,
    input  wire        I_IRQ,
    input  wire [5:0]  I_COMPL_SIG,
    output wire        O_LED_0,
    output wire        O_LED_1
);
    reg  [2:0]  compl_sel_q;
    reg  [2:0]  compl_sel_d;
    reg         pol0_q;
    reg         pol0_d;
    reg         pol1_q;
    reg         pol1_d;
    reg  [2:0]  src0_q;
    reg  [2:0]  src0_d;
    reg  [2:0]  src1_q;
    reg  [2:0]  src1_d;
    reg  [3:0]  opt0_q;
    reg  [3:0]  opt0_d;
    reg  [3:0]  opt1_q;
    reg  [3:0]  opt1_d;
    reg  [4:0]  s1_q;
    reg  [4:0]  s2_q;
    reg  [5:0]  c1_q;
    reg  [5:0]  c2_q;
    reg  [31:0] blink_cnt_q;
    reg         blink_q;
    reg  [31:0] rdata_d;
    reg         err_d;
    wire [11:0] idx;
    wire        setup;
    wire        hit_compl;
    wire        hit_src;
    wire        hit_opt;
    wire        wr_compl;
    wire        wr_src;
    wire        wr_opt;
    wire        compl_bit;

    assign idx   = I_PADDR[13:2];
    assign setup = I_PSEL & ~I_PENABLE;

    // Register hits; a write is stored at its setup edge
    assign hit_compl = (idx == `IDX_COMPL_POL);
    assign hit_src   = (idx == `IDX_SRC_SEL);
    assign hit_opt   = (idx == `IDX_OPTIONS);
    assign wr_compl  = setup & I_PWRITE & hit_compl;
    assign wr_src    = setup & I_PWRITE & hit_src;
    assign wr_opt    = setup & I_PWRITE & hit_opt;

    // Two-flop synchronisers for the asynchronous status inputs
    always @(posedge I_CLK) begin
        if (!I_RST_B) begin
            s1_q <= 5'h00;
            s2_q <= 5'h00;
            c1_q <= 6'h00;
            c2_q <= 6'h00;
        end else begin
            // Bit order: interrupt, link, activity, match, under-voltage
            s1_q <= {I_IRQ, I_LINK_UP, I_ACTIVITY, I_DATA_MATCH, I_UNDER_VOLT};
            s2_q <= s1_q;
            c1_q <= I_COMPL_SIG;
            c2_q <= c1_q;
        end
    end

    // Compliance signals beyond code 101b read as zero
    assign compl_bit = (compl_sel_q <= 3'h5) ? c2_q[compl_sel_q] : 1'b0;

    always @(posedge I_CLK) begin
        if (!I_RST_B) begin
            blink_cnt_q <= 32'h0000_0000;
            blink_q     <= 1'b0;
        end else if (blink_cnt_q == `BLINK_CYC - 1) begin
            blink_cnt_q <= 32'h0000_0000;
            blink_q     <= ~blink_q;
        end else begin
            blink_cnt_q <= blink_cnt_q + 32'h0000_0001;
        end
    end

    always @* begin
        rdata_d = 32'h0000_0000;
        err_d   = 1'b0;
        if (idx == `IDX_COMPL_POL) begin
            rdata_d[`COMPL_SEL_HI:`COMPL_SEL_LO] = compl_sel_q;
            rdata_d[`POL1_BIT] = pol1_q;
            rdata_d[`POL0_BIT] = pol0_q;
        end else if (idx == `IDX_SRC_SEL) begin
            rdata_d[`SRC1_HI:`SRC1_LO] = src1_q;
            rdata_d[`SRC0_HI:`SRC0_LO] = src0_q;
        end else if (idx == `IDX_OPTIONS) begin
            rdata_d[`OPT1_HI:`OPT1_LO] = opt1_q;
            rdata_d[`OPT0_HI:`OPT0_LO] = opt0_q;
        end else begin
            err_d = 1'b1;
        end
    end

    // Next register values; reserved bits are never stored
    always @* begin
        compl_sel_d = compl_sel_q;
        pol1_d      = pol1_q;
        pol0_d      = pol0_q;
        src1_d      = src1_q;
        src0_d      = src0_q;
        opt1_d      = opt1_q;
        opt0_d      = opt0_q;
        if (wr_compl) begin
            compl_sel_d = I_PWDATA[`COMPL_SEL_HI:`COMPL_SEL_LO];
            pol1_d      = I_PWDATA[`POL1_BIT];
            pol0_d      = I_PWDATA[`POL0_BIT];
        end
        if (wr_src) begin
            src1_d = I_PWDATA[`SRC1_HI:`SRC1_LO];
            src0_d = I_PWDATA[`SRC0_HI:`SRC0_LO];
        end
        if (wr_opt) begin
            opt1_d = I_PWDATA[`OPT1_HI:`OPT1_LO];
            opt0_d = I_PWDATA[`OPT0_HI:`OPT0_LO];
        end
    end

    // Configuration registers
    always @(posedge I_CLK) begin
        if (!I_RST_B) begin
            compl_sel_q <= `RST_COMPL_SEL;
            pol1_q      <= 1'b0;
            pol0_q      <= 1'b0;
            src1_q      <= `RST_SRC;
            src0_q      <= `RST_SRC;
            opt1_q      <= `RST_OPT1;
            opt0_q      <= `RST_OPT0;
        end else begin
            compl_sel_q <= compl_sel_d;
            pol1_q      <= pol1_d;
            pol0_q      <= pol0_d;
            src1_q      <= src1_d;
            src0_q      <= src0_d;
            opt1_q      <= opt1_d;
            opt0_q      <= opt0_d;
        end
    end

    // No wait state: pready rises in the first access cycle
    always @(posedge I_CLK) begin
        if (!I_RST_B) begin
            O_PREADY  <= 1'b0;
            O_PRDATA  <= 32'h0000_0000;
            O_PSLVERR <= 1'b0;
        end else begin
            O_PREADY  <= setup;
            O_PSLVERR <= setup & err_d;
            if (setup & ~I_PWRITE) begin
                O_PRDATA <= rdata_d;
            end else begin
                O_PRDATA <= 32'h0000_0000;
            end
        end
    end

    led_pin_source u_pin0 (
        .i_clk   (I_CLK),
        .i_rst_b (I_RST_B),
        .i_sel   (src0_q),
        .i_opt   (opt0_q),
        .i_pol   (pol0_q),
        .i_link  (s2_q[3]),
        .i_act   (s2_q[2]),
        .i_blink (blink_q),
        .i_match (s2_q[1]),
        .i_uvolt (s2_q[0]),
        .i_irq   (s2_q[4]),
        .i_compl (compl_bit),
        .o_pin   (O_LED_0)
    );

    led_pin_source u_pin1 (
        .i_clk   (I_CLK),
        .i_rst_b (I_RST_B),
        .i_sel   (src1_q),
        .i_opt   (opt1_q),
        .i_pol   (pol1_q),
        .i_link  (s2_q[3]),
        .i_act   (s2_q[2]),
        .i_blink (blink_q),
        .i_match (s2_q[1]),
        .i_uvolt (s2_q[0]),
        .i_irq   (s2_q[4]),
        .i_compl (compl_bit),
        .o_pin   (O_LED_1)
    );
endmodule
`default_nettype wire

// [hdl/unused_note.v]
// Holds no logic
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// [verification/led_mux_monitor.sv]
// Assertions on the APB answer and the pin levels of the indicator pin mux
`timescale 1ns/1ps
`default_nettype none
module led_mux_monitor (
    input wire logic        I_CLK,
    input wire logic        I_RST_B,
    input wire logic        I_PSEL,
    input wire logic        I_PENABLE,
    input wire logic        I_PWRITE,
    input wire logic [13:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    input wire logic        O_PREADY,
    input wire logic [31:0] O_PRDATA,
    input wire logic        O_PSLVERR,
    input wire logic        O_LED_0,
    input wire logic        O_LED_1
);
    wire logic st = I_PSEL && !I_PENABLE;
    wire logic ws = st && I_PWRITE && I_PADDR[13:2] == 12'h452;
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_RST_B);
    property p_rdy; st |=> O_PREADY; endproperty
    a_rdy: assert property (p_rdy) else $error("no ready after setup");
    property p_pulse; O_PREADY |=> !O_PREADY; endproperty
    a_pulse: assert property (p_pulse) else $error("ready too long");
    property p_idle; !O_PREADY |-> O_PRDATA == 32'h0 && !O_PSLVERR; endproperty
    a_idle: assert property (p_idle) else $error("answer outside access");
    property p_unm; st && !(I_PADDR[13:2] inside {12'h451, 12'h452, 12'h454})
        |=> O_PSLVERR && O_PRDATA == 32'h0; endproperty
    a_unm: assert property (p_unm) else $error("unmapped not refused");
    property p_hi; O_PREADY |-> O_PRDATA[31:16] == 16'h0; endproperty
    a_hi: assert property (p_hi) else $error("upper half not zero");
    property p_led0; ws && I_PWDATA[2:1] == 2'b11 |=> ##1 O_LED_0 == $past(I_PWDATA[0], 2); endproperty
    a_led0: assert property (p_led0) else $error("pin 0 not forced");
    property p_led1; ws && I_PWDATA[10:9] == 2'b11 |=> ##1 O_LED_1 == $past(I_PWDATA[8], 2); endproperty
    a_led1: assert property (p_led1) else $error("pin 1 not forced");
    property p_rst; disable iff (1'b0) !I_RST_B |=> !O_PREADY && !O_LED_0 && !O_LED_1; endproperty
    a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
endmodule
bind led_pin_output_mux led_mux_monitor led_mux_monitor_inst (.I_CLK(I_CLK), .I_RST_B(I_RST_B),
    .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
    .I_PWDATA(I_PWDATA), .O_PREADY(O_PREADY), .O_PRDATA(O_PRDATA), .O_PSLVERR(O_PSLVERR),
    .O_LED_0(O_LED_0), .O_LED_1(O_LED_1));
`default_nettype wire

// [verification/testbench.sv]
// Random self-checking bench for the indicator pin mux
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clk = 0, rst_b = 0, psel = 0, pen = 0, pwr = 0, err;
    logic        link = 0, act = 0, mat = 0, uv = 0, irq = 0;
    logic [13:0] addr = 0;
    logic [31:0] wd = 0, rd;
    logic [5:0]  cmp = 0;
    wire         rdy, slv, led0, led1;
    wire  [31:0] prd;
    int          n_mismatch = 0, num_checks = 0, s0, s1, cs, p0, p1;
    always #10 clk = ~clk;
    led_pin_output_mux led_pin_output_mux_inst (.I_CLK(clk), .I_RST_B(rst_b), .I_PSEL(psel),
        .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(addr), .I_PWDATA(wd), .O_PREADY(rdy),
        .O_PRDATA(prd), .O_PSLVERR(slv), .I_LINK_UP(link), .I_ACTIVITY(act), .I_DATA_MATCH(mat),
        .I_UNDER_VOLT(uv), .I_IRQ(irq), .I_COMPL_SIG(cmp), .O_LED_0(led0), .O_LED_1(led1));
    task final_report;
        $display("mismatches %0d checks %0d", n_mismatch, num_checks);
        if (n_mismatch == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task apb(input logic w, input logic [13:0] a, input logic [31:0] d);
        int n;
        psel <= 1;
        pwr <= w;
        addr <= a;
        wd <= d;
        @(posedge clk);
        pen <= 1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (rdy !== 1'b1 && n < 20);
        if (rdy !== 1'b1) begin
            n_mismatch++;
            final_report;
        end else begin
            rd = prd;
            err = slv;
            psel <= 0;
            pen <= 0;
            @(posedge clk);
        end
    endtask
    function logic exp_led(input int s, input int p, input logic own);
        case (s)
            0: return own ^ p[0];
            2: return mat;
            3: return uv;
            4: return irq;
            5: return (cs < 6) ? cmp[cs] : 1'b0;
            7: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction
    initial begin
        void'($urandom(25555));
        repeat (12) @(posedge clk);
        rst_b <= 1;
        link <= 1;
        @(posedge clk);
        apb(0, 14'h1144, 0);
        chk("compliance reg", rd, 0);
        apb(0, 14'h1148, 0);
        chk("source reg", rd, 0);
        chk("pin 0", led0, 1);
        chk("pin 1", led1, 1);
        apb(0, 14'h1150, 0);
        chk("options reg", rd, 32'h0010);
        apb(1, 14'h1144, '1);
        apb(0, 14'h1144, 0);
        chk("compliance reg", rd, 32'h0e09);
        apb(1, 14'h1148, '1);
        apb(0, 14'h1148, 0);
        chk("source reg", rd, 32'h0707);
        apb(0, 14'h1000, 0);
        chk("error flag", err, 1);
        for (int i = 0; i < 70; i++) begin
            s0 = i % 7 == 0 ? 0 : i % 7 + 1;
            s1 = $urandom_range(6);
            s1 = s1 + (s1 > 0);
            cs = i % 8;
            p0 = $urandom_range(1);
            p1 = $urandom_range(1);
            apb(1, 14'h1144, 32'((cs << 9) | (p1 << 3) | p0));
            apb(1, 14'h1148, 32'((s1 << 8) | s0));
            apb(1, 14'h1150, 32'($urandom_range(255)));
            link <= 1'($urandom);
            mat <= 1'($urandom);
            uv <= 1'($urandom);
            irq <= 1'($urandom);
            act <= 1'($urandom);
            cmp <= 6'($urandom);
            repeat (4) @(posedge clk);
            // Blink phase stays low far longer than this run: every option shows link
            chk("pin 0", led0, exp_led(s0, p0, link));
            chk("pin 1", led1, exp_led(s1, p1, link));
        end
        rst_b <= 0;
        repeat (3) @(posedge clk);
        rst_b <= 1;
        @(posedge clk);
        apb(0, 14'h1144, 0);
        chk("compliance reg", rd, 0);
        apb(0, 14'h1148, 0);
        chk("source reg", rd, 0);
        apb(0, 14'h1150, 0);
        chk("options reg", rd, 32'h0010);
        chk("pin 0", led0, link);
        chk("pin 1", led1, link);
        final_report;
    end
    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        final_report;
    end
endmodule
`default_nettype wire
